//--- rtl/fwsr_cfg.svh
`ifndef FWSR_CFG_SVH
`define FWSR_CFG_SVH

// timing
`define FWSR_CLK_NS 20
`define FWSR_T_STROBE_NS 70
`define FWSR_STROBE_CYC ((`FWSR_T_STROBE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_SYNC_LAT 3

// software register offsets
`define FWSR_REG_CTRL 8'h00
`define FWSR_REG_ADDR 8'h04
`define FWSR_REG_DATA 8'h08
`define FWSR_REG_STAT 8'h0C
`define FWSR_REG_RDAT 8'h10

// control register fields
`define FWSR_CTRL_OP_LSB 0
`define FWSR_CTRL_START 8
`define FWSR_CTRL_ABORT 9

// status register fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_RDY 3
`define FWSR_ST_ERR 4
`define FWSR_ST_POLLOK 5
`define FWSR_ST_SELTGL 6
`define FWSR_ST_TIMER 7
`define FWSR_ST_BYTE_LSB 8

// status bits on the flash data bus
`define FWSR_POLL_BIT 7
`define FWSR_TGL1_BIT 6
`define FWSR_ERR_BIT 5
`define FWSR_TIMER_BIT 3
`define FWSR_TGL2_BIT 2

// command cycles
`define FWSR_UNLOCK_A1 20'h00555
`define FWSR_UNLOCK_A2 20'h002AA
`define FWSR_UNLOCK_D1 8'hAA
`define FWSR_UNLOCK_D2 8'h55
`define FWSR_CMD_PROG 8'hA0
`define FWSR_CMD_ERASE_SETUP 8'h80
`define FWSR_CMD_CHIP 8'h10
`define FWSR_CMD_SECTOR 8'h30
`define FWSR_CMD_RESET 8'hF0
`define FWSR_LEN_PROG 3'h4
`define FWSR_LEN_ERASE 3'h6
`define FWSR_LEN_RESET 3'h1

`endif

//--- rtl/fwsr_pkg.sv
package fwsr_pkg;

    typedef enum logic [2:0] {
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_RESET,
        OP_READ
    } fwsr_op_type;

    typedef enum {
        BC_IDLE,
        BC_SETUP,
        BC_STROBE,
        BC_HOLD
    } fwsr_bc_phase_type;

    typedef enum {
        S_IDLE,
        S_ISSUE,
        S_WAIT_CMD,
        S_RD_A,
        S_WAIT_A,
        S_RD_B,
        S_WAIT_B,
        S_EVAL,
        S_RST_WR,
        S_WAIT_RST,
        S_FINAL,
        S_WAIT_FINAL
    } fwsr_state_type;

endpackage : fwsr_pkg

//--- rtl/fwsr_sync.sv
`timescale 1ns/1ns
module fwsr_sync import fwsr_pkg::*; #(
    parameter int W = 8
) (
    // clock
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // level in, filtered level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fwsr_sync_type;

    fwsr_sync_type r_q;
    fwsr_sync_type r_d;

    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        // a bit moves only once the second and third stages agree
        for (int i = 0; i < W; i++) begin
            if (r_q.s2[i] == r_q.s3[i]) begin
                r_d.q[i] = r_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_q <= '0;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign q = r_q.q;
endmodule : fwsr_sync

//--- rtl/fwsr_bus_cycle.sv
`timescale 1ns/1ns
`include "fwsr_cfg.svh"
module fwsr_bus_cycle import fwsr_pkg::*; #(
    parameter int AW = 20,
    parameter int DW = 8
) (
    // clock
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // request
    input wire logic start,
    input wire logic wr,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic done,
    output logic [DW-1:0] rdata,
    // flash pins
    input wire logic [DW-1:0] dq_sync,
    output logic [AW-1:0] pin_addr,
    output logic [DW-1:0] pin_dq_o,
    output logic pin_dq_oe_n,
    output logic pin_ce_n,
    output logic pin_oe_n,
    output logic pin_we_n
);
    localparam logic [7:0] STROBE_CYC = 8'(`FWSR_STROBE_CYC);
    localparam logic [7:0] READ_CYC = 8'(`FWSR_STROBE_CYC + `FWSR_SYNC_LAT + 1);

    typedef struct packed {
        fwsr_bc_phase_type ph;
        logic wr;
        logic [7:0] cnt;
        logic [AW-1:0] a;
        logic [DW-1:0] dout;
        logic doe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [DW-1:0] rdata;
        logic done;
    } fwsr_bc_type;

    localparam fwsr_bc_type BC_RST = '{ph: BC_IDLE, wr: 1'b0, cnt: 8'h00, a: '0, dout: '0,
        doe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rdata: '0, done: 1'b0};

    fwsr_bc_type r_q;
    fwsr_bc_type r_d;

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        case (r_q.ph)
            BC_IDLE: begin
                if (start) begin
                    r_d.ph = BC_SETUP;
                    r_d.wr = wr;
                    r_d.a = addr;
                    r_d.dout = wdata;
                    r_d.doe_n = ~wr;
                    r_d.ce_n = 1'b0;
                end
            end
            BC_SETUP: begin
                r_d.ph = BC_STROBE;
                r_d.we_n = ~r_q.wr;
                r_d.oe_n = r_q.wr;
                r_d.cnt = r_q.wr ? STROBE_CYC : READ_CYC;
            end
            BC_STROBE: begin
                r_d.cnt = r_q.cnt - 8'h01;
                if (r_q.cnt == 8'h01) begin
                    // both strobes rise here, so every read is a fresh strobe
                    r_d.ph = BC_HOLD;
                    r_d.we_n = 1'b1;
                    r_d.oe_n = 1'b1;
                    if (!r_q.wr) begin
                        r_d.rdata = dq_sync;
                    end
                end
            end
            BC_HOLD: begin
                r_d.ph = BC_IDLE;
                r_d.ce_n = 1'b1;
                r_d.doe_n = 1'b1;
                r_d.done = 1'b1;
            end
            default: r_d = BC_RST;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_q <= BC_RST;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign done = r_q.done;
    assign rdata = r_q.rdata;
    assign pin_addr = r_q.a;
    assign pin_dq_o = r_q.dout;
    assign pin_dq_oe_n = r_q.doe_n;
    assign pin_ce_n = r_q.ce_n;
    assign pin_oe_n = r_q.oe_n;
    assign pin_we_n = r_q.we_n;
endmodule : fwsr_bus_cycle

//--- rtl/fwsr_ctrl.sv
// What this block does
// - host polls at the address of the programmed or erased sector
// - final data is taken from a read after polling ends
// - programming one over zero fails; host then writes reset
// - on error bit high the host checks toggling once more
// - host combines both toggle bits for sector and mode information
// - host reads the status byte twice and compares
// - still toggling with error high means failure and a reset write
// - host restarts the toggle check from its first step when resuming
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "fwsr_cfg.svh"
module fwsr_ctrl import fwsr_pkg::*; #(
    parameter int AW = 20,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // software register port
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic op_busy,
    // flash pins
    output logic [AW-1:0] flash_addr,
    input wire logic [DW-1:0] flash_dq_i,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic op_progress_pin
);
    typedef struct packed {
        fwsr_state_type st;
        fwsr_op_type op;
        logic [AW-1:0] op_addr;
        logic [DW-1:0] op_data;
        logic [2:0] step;
        logic bc_start;
        logic bc_wr;
        logic [AW-1:0] bc_a;
        logic [DW-1:0] bc_d;
        logic [DW-1:0] first_rd;
        logic [DW-1:0] last_rd;
        logic recheck;
        logic busy;
        logic done;
        logic fail;
        logic err_seen;
        logic poll_ok;
        logic sel_toggle;
        logic timer_seen;
        logic [DW-1:0] array_data;
        logic [31:0] rdata;
    } fwsr_ctrl_type;

    localparam fwsr_ctrl_type CTRL_RST = '{st: S_IDLE, op: OP_PROGRAM, step: 3'h0,
        default: '0};

    fwsr_ctrl_type r_q;
    fwsr_ctrl_type r_d;

    logic bc_done;
    logic [DW-1:0] bc_rdata;
    logic [DW-1:0] dq_sync;
    logic rdy_sync;

    fwsr_sync #(.W(DW + 1)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d({op_progress_pin, flash_dq_i}),
        .q({rdy_sync, dq_sync})
    );

    fwsr_bus_cycle #(.AW(AW), .DW(DW)) u_bc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(r_q.bc_start),
        .wr(r_q.bc_wr),
        .addr(r_q.bc_a),
        .wdata(r_q.bc_d),
        .done(bc_done),
        .rdata(bc_rdata),
        .dq_sync(dq_sync),
        .pin_addr(flash_addr),
        .pin_dq_o(flash_dq_o),
        .pin_dq_oe_n(flash_dq_oe_n),
        .pin_ce_n(flash_ce_n),
        .pin_oe_n(flash_oe_n),
        .pin_we_n(flash_we_n)
    );

    function automatic logic [2:0] seq_len(input fwsr_op_type op);
        case (op)
            OP_PROGRAM: seq_len = `FWSR_LEN_PROG;
            OP_CHIP_ERASE: seq_len = `FWSR_LEN_ERASE;
            OP_SECTOR_ERASE: seq_len = `FWSR_LEN_ERASE;
            OP_RESET: seq_len = `FWSR_LEN_RESET;
            default: seq_len = 3'h0;
        endcase
    endfunction : seq_len

    // address and data of one command write
    function automatic logic [AW+DW-1:0] seq_word(input fwsr_op_type op,
            input logic [2:0] s, input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic prog;
        prog = (op == OP_PROGRAM);
        seq_word = {`FWSR_UNLOCK_A1, `FWSR_UNLOCK_D1};
        if (op == OP_RESET) begin
            seq_word = {`FWSR_UNLOCK_A1, `FWSR_CMD_RESET};
        end else begin
            case (s)
                3'h0: seq_word = {`FWSR_UNLOCK_A1, `FWSR_UNLOCK_D1};
                3'h1: seq_word = {`FWSR_UNLOCK_A2, `FWSR_UNLOCK_D2};
                3'h2: seq_word = prog ? {`FWSR_UNLOCK_A1, `FWSR_CMD_PROG}
                                      : {`FWSR_UNLOCK_A1, `FWSR_CMD_ERASE_SETUP};
                3'h3: seq_word = prog ? {a, d} : {`FWSR_UNLOCK_A1, `FWSR_UNLOCK_D1};
                3'h4: seq_word = {`FWSR_UNLOCK_A2, `FWSR_UNLOCK_D2};
                3'h5: seq_word = (op == OP_CHIP_ERASE) ? {`FWSR_UNLOCK_A1, `FWSR_CMD_CHIP}
                                                       : {a, `FWSR_CMD_SECTOR};
                default: seq_word = {`FWSR_UNLOCK_A1, `FWSR_CMD_RESET};
            endcase
        end
    endfunction : seq_word

    always_comb begin
        logic toggling;
        logic [AW+DW-1:0] w;
        toggling = 1'b0;
        w = '0;
        r_d = r_q;
        r_d.bc_start = 1'b0;

        // software side
        if (sw_wr) begin
            case (sw_addr)
                `FWSR_REG_ADDR: r_d.op_addr = sw_wdata[AW-1:0];
                `FWSR_REG_DATA: r_d.op_data = sw_wdata[DW-1:0];
                `FWSR_REG_CTRL: begin
                    if (sw_wdata[`FWSR_CTRL_ABORT]) begin
                        // leaving the poll loop; a later start begins at step one
                        r_d.st = S_IDLE;
                        r_d.busy = 1'b0;
                    end else if (sw_wdata[`FWSR_CTRL_START] && !r_q.busy && flash_ce_n
                                 && !r_q.bc_start) begin
                        // a cycle left over from an abort drains first, or its done
                        // would be taken for the first command write
                        r_d.op = fwsr_op_type'(sw_wdata[`FWSR_CTRL_OP_LSB +: 3]);
                        r_d.st = (r_d.op == OP_READ) ? S_FINAL : S_ISSUE;
                        r_d.step = 3'h0;
                        r_d.busy = 1'b1;
                        r_d.done = 1'b0;
                        r_d.fail = 1'b0;
                        r_d.err_seen = 1'b0;
                        r_d.poll_ok = 1'b0;
                        r_d.sel_toggle = 1'b0;
                        r_d.timer_seen = 1'b0;
                        r_d.recheck = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (sw_rd) begin
            case (sw_addr)
                `FWSR_REG_CTRL: r_d.rdata = {29'h0, r_q.op};
                `FWSR_REG_ADDR: r_d.rdata = 32'(r_q.op_addr);
                `FWSR_REG_DATA: r_d.rdata = 32'(r_q.op_data);
                `FWSR_REG_STAT: begin
                    r_d.rdata = '0;
                    r_d.rdata[`FWSR_ST_BUSY] = r_q.busy;
                    r_d.rdata[`FWSR_ST_DONE] = r_q.done;
                    r_d.rdata[`FWSR_ST_FAIL] = r_q.fail;
                    r_d.rdata[`FWSR_ST_RDY] = rdy_sync;
                    r_d.rdata[`FWSR_ST_ERR] = r_q.err_seen;
                    r_d.rdata[`FWSR_ST_POLLOK] = r_q.poll_ok;
                    r_d.rdata[`FWSR_ST_SELTGL] = r_q.sel_toggle;
                    r_d.rdata[`FWSR_ST_TIMER] = r_q.timer_seen;
                    r_d.rdata[`FWSR_ST_BYTE_LSB +: DW] = r_q.last_rd;
                end
                `FWSR_REG_RDAT: r_d.rdata = 32'(r_q.array_data);
                default: r_d.rdata = '0;
            endcase
        end

        // flash side
        case (r_q.st)
            S_IDLE: ;
            S_ISSUE: begin
                w = seq_word(r_q.op, r_q.step, r_q.op_addr, r_q.op_data);
                r_d.bc_start = 1'b1;
                r_d.bc_wr = 1'b1;
                r_d.bc_a = w[AW+DW-1:DW];
                r_d.bc_d = w[DW-1:0];
                r_d.st = S_WAIT_CMD;
            end
            S_WAIT_CMD: begin
                if (bc_done) begin
                    r_d.step = r_q.step + 3'h1;
                    if (r_q.step + 3'h1 != seq_len(r_q.op)) begin
                        r_d.st = S_ISSUE;
                    end else if (r_q.op == OP_RESET) begin
                        r_d.st = S_FINAL;
                    end else begin
                        // status is valid only after the last command write
                        r_d.st = S_RD_A;
                    end
                end
            end
            S_RD_A, S_RD_B, S_FINAL: begin
                r_d.bc_start = 1'b1;
                r_d.bc_wr = 1'b0;
                r_d.bc_a = r_q.op_addr;
                r_d.st = (r_q.st == S_RD_A) ? S_WAIT_A :
                         (r_q.st == S_RD_B) ? S_WAIT_B : S_WAIT_FINAL;
            end
            S_WAIT_A: begin
                if (bc_done) begin
                    r_d.first_rd = bc_rdata;
                    r_d.st = S_RD_B;
                end
            end
            S_WAIT_B: begin
                if (bc_done) begin
                    r_d.last_rd = bc_rdata;
                    r_d.st = S_EVAL;
                end
            end
            S_EVAL: begin
                // two reads in a row, compared
                toggling = r_q.first_rd[`FWSR_TGL1_BIT] ^ r_q.last_rd[`FWSR_TGL1_BIT];
                if (r_q.first_rd[`FWSR_TGL2_BIT] ^ r_q.last_rd[`FWSR_TGL2_BIT]) begin
                    r_d.sel_toggle = 1'b1;
                end
                if (r_q.last_rd[`FWSR_TIMER_BIT] && r_q.op == OP_SECTOR_ERASE) begin
                    r_d.timer_seen = 1'b1;
                end
                if (!toggling) begin
                    // stopped toggle means finished, protected cases included
                    if (r_q.op == OP_PROGRAM) begin
                        r_d.poll_ok = (r_q.last_rd[`FWSR_POLL_BIT]
                                       == r_q.op_data[`FWSR_POLL_BIT]);
                    end else begin
                        r_d.poll_ok = r_q.last_rd[`FWSR_POLL_BIT];
                    end
                    r_d.st = S_FINAL;
                end else if (r_q.last_rd[`FWSR_ERR_BIT]) begin
                    r_d.err_seen = 1'b1;
                    if (r_q.recheck) begin
                        // still toggling with error: failed, write reset
                        r_d.fail = 1'b1;
                        r_d.st = S_RST_WR;
                    end else begin
                        // it may have just finished as the error rose
                        r_d.recheck = 1'b1;
                        r_d.st = S_RD_A;
                    end
                end else begin
                    r_d.st = S_RD_A;
                end
            end
            S_RST_WR: begin
                r_d.bc_start = 1'b1;
                r_d.bc_wr = 1'b1;
                r_d.bc_a = `FWSR_UNLOCK_A1;
                r_d.bc_d = `FWSR_CMD_RESET;
                r_d.st = S_WAIT_RST;
            end
            S_WAIT_RST: begin
                if (bc_done) begin
                    r_d.st = S_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            S_WAIT_FINAL: begin
                if (bc_done) begin
                    // the read after polling carries valid data on all bits
                    r_d.array_data = bc_rdata;
                    r_d.st = S_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            default: r_d.st = S_IDLE;
        endcase
        // abort wins over whatever the poll loop chose in the same cycle
        if (sw_wr && sw_addr == `FWSR_REG_CTRL && sw_wdata[`FWSR_CTRL_ABORT]) begin
            r_d.st = S_IDLE;
            r_d.busy = 1'b0;
            r_d.bc_start = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_q <= CTRL_RST;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign sw_rdata = r_q.rdata;
    assign op_busy = r_q.busy;
endmodule : fwsr_ctrl

//--- test/fwsr_ctrl_properties.sv
`timescale 1ns/1ns
module fwsr_ctrl_checker #(
    parameter int AW = 20,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // software port
    input wire logic [7:0] sw_addr,
    input wire logic sw_rd,
    input wire logic [31:0] sw_rdata,
    input wire logic op_busy,
    // flash pins
    input wire logic [AW-1:0] flash_addr,
    input wire logic [DW-1:0] flash_dq_o,
    input wire logic flash_dq_oe_n,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    reset_idle_pins_a: assert property ($fell(sys_rst) |-> flash_ce_n && flash_oe_n
        && flash_we_n && flash_dq_oe_n && !op_busy && sw_rdata == 32'h0)
        else $error("pins not idle after reset");
    write_frame_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n
        && !flash_dq_oe_n && $stable(flash_dq_o) && $stable(flash_addr))
        else $error("write strobe outside a held write frame");
    read_frame_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n
        && flash_dq_oe_n) else $error("read strobe while host drives the bus");
    write_width_a: assert property ($fell(flash_we_n) |->
        (!flash_we_n)[*4] ##1 flash_we_n) else $error("write strobe width wrong");
    read_width_a: assert property ($fell(flash_oe_n) |->
        (!flash_oe_n)[*8] ##1 flash_oe_n) else $error("read strobe width wrong");
    frame_entry_a: assert property ($fell(flash_ce_n) |-> flash_we_n && flash_oe_n)
        else $error("strobe active as chip select falls");
    frame_exit_a: assert property ($rose(flash_ce_n) |-> $past(flash_we_n)
        && $past(flash_oe_n) ##1 flash_ce_n) else $error("frame released badly");
    unmapped_read_a: assert property (sw_rd && sw_addr == 8'h14 |=> sw_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : fwsr_ctrl_checker

bind fwsr_ctrl fwsr_ctrl_checker #(.AW(AW), .DW(DW)) i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .op_busy(op_busy), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);

//--- test/fwsr_flash_model.sv
`timescale 1ns/1ns
module fwsr_flash_model (
    // host side
    input wire logic [19:0] addr,
    input wire logic [7:0] dq_host,
    input wire logic dq_oe_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    // reads an operation stays busy for
    input wire logic [7:0] busy_reads,
    // device outputs
    output logic [7:0] dq_bus,
    output logic ready_pin
);
    logic [7:0] mem [0:255];
    logic [47:0] hist = 48'h0;
    logic [7:0] last_d = 8'h00, left = 8'h00, drive = 8'h00, pa = 8'h00;
    logic [1:0] mode = 2'h0;
    logic tgl = 1'h0, tgl2 = 1'h0, err = 1'h0, bad = 1'h0;
    initial foreach (mem[i]) mem[i] = 8'h00;

    always @(posedge we_n) if (!ce_n) begin
        hist = {hist[39:0], dq_host};
        if (dq_host == 8'hF0) begin
            hist = 48'h0;
            // a running operation ignores reset unless it has failed
            if (bad) begin
                mode = 2'h0;
                err = 1'h0;
                bad = 1'h0;
            end
        end else if (mode == 2'h0 && hist[31:8] == 24'hAA55A0) begin
            mode = 2'h1;
            pa = addr[7:0];
            last_d = dq_host;
            left = busy_reads;
            bad = |(dq_host & ~mem[addr[7:0]]);
        end else if (mode == 2'h0 && hist[47:8] == 40'hAA5580AA55) begin
            mode = (dq_host == 8'h30) ? 2'h3 : 2'h2;
            left = busy_reads;
        end
    end

    always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) begin
        if (mode != 2'h0 && left == 8'h00 && !bad) begin
            if (mode == 2'h1) mem[pa] = last_d;
            // no sector map kept: any erase wipes the whole array
            else foreach (mem[i]) mem[i] = 8'hFF;
            mode = 2'h0;
        end
        if (mode != 2'h0) begin
            if (left != 8'h00) left = left - 8'h01;
            else err = bad;
            tgl = ~tgl;
            tgl2 = tgl2 ^ mode[1];
            drive = (mode == 2'h1) ? {~last_d[7], tgl, err, 5'h00}
                : {1'h0, tgl, 2'h0, mode[0], tgl2, 2'h0};
        end else drive = mem[addr[7:0]];
    end
    // a released bus shows the inverse of the last value, never a kept one
    assign dq_bus = !dq_oe_n ? dq_host : (!oe_n && !ce_n) ? drive : ~drive;
    assign ready_pin = (mode == 2'h0);
endmodule : fwsr_flash_model

//--- test/flash_write_status_reporting_test.sv
`timescale 1ns/1ns
`include "fwsr_cfg.svh"
module flash_write_status_reporting_test import fwsr_pkg::*;;
    typedef struct packed {
        fwsr_op_type op;
        logic [19:0] a;
        logic [7:0] d, nb, mask, stat, rmask, rdat;
    } fwsr_row_type;
    localparam fwsr_row_type ROWS [7] = '{
        '{OP_CHIP_ERASE, 20'h00000, 8'h00, 8'h02, 8'hFF, 8'h6A, 8'hFF, 8'hFF},
        '{OP_PROGRAM, 20'h00023, 8'h5A, 8'h03, 8'hFF, 8'h2A, 8'hFF, 8'h5A},
        '{OP_PROGRAM, 20'h00023, 8'hA5, 8'h02, 8'h1F, 8'h1E, 8'h00, 8'h00},
        '{OP_SECTOR_ERASE, 20'h00023, 8'h00, 8'h04, 8'hFF, 8'hEA, 8'hFF, 8'hFF},
        '{OP_PROGRAM, 20'h00040, 8'h3C, 8'h00, 8'hFF, 8'h2A, 8'hFF, 8'h3C},
        '{OP_RESET, 20'h00040, 8'h00, 8'h00, 8'h0F, 8'h0A, 8'hFF, 8'h3C},
        '{OP_READ, 20'h00023, 8'h00, 8'h00, 8'h0F, 8'h0A, 8'hFF, 8'hFF}
    };
    logic clk_sys, sys_rst = 1'h1, sw_wr = 1'h0, sw_rd = 1'h0, op_busy, ready_pin;
    logic [7:0] sw_addr = 8'h00, busy_reads = 8'h00, flash_dq_i, flash_dq_o;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, s;
    logic [19:0] flash_addr;
    logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
    int fail_count = 0, n_checks = 0;

    fwsr_ctrl #(.AW(20), .DW(8)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'h1), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .op_busy(op_busy), .flash_addr(flash_addr), .flash_dq_i(flash_dq_i),
        .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .op_progress_pin(ready_pin)
    );
    fwsr_flash_model i_flash (
        .addr(flash_addr), .dq_host(flash_dq_o), .dq_oe_n(flash_dq_oe_n), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .busy_reads(busy_reads), .dq_bus(flash_dq_i),
        .ready_pin(ready_pin)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // an edge passes after each strobe so the next call never reassigns it in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'h1;
        @(posedge clk_sys);
        sw_wr <= 1'h0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        sw_addr <= a;
        sw_rd <= 1'h1;
        @(posedge clk_sys);
        sw_rd <= 1'h0;
        @(posedge clk_sys);
        d = sw_rdata;
    endtask : rd
    task automatic start_op(input fwsr_op_type op, input logic [19:0] a, input logic [7:0] d);
        wr(`FWSR_REG_ADDR, {12'h000, a});
        wr(`FWSR_REG_DATA, {24'h000000, d});
        wr(`FWSR_REG_CTRL, {23'h000000, 1'h1, 5'h00, op});
        repeat (2) @(posedge clk_sys);
        chk("busy after start", op_busy, 32'h1);
    endtask : start_op
    task automatic wait_idle();
        int i;
        s = 32'h1;
        for (i = 0; i < 1000 && s[0] !== 1'h0; i++) rd(`FWSR_REG_STAT, s);
        chk("finished in time", s[0], 32'h0);
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #1200000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        chk("idle pins", {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, op_busy}, 32'h1E);
        rd(8'h14, s);
        chk("unmapped read", s, 32'h0);
        // polling stays at the operation address throughout
        foreach (ROWS[i]) begin
            busy_reads <= ROWS[i].nb;
            start_op(ROWS[i].op, ROWS[i].a, ROWS[i].d);
            wait_idle();
            rd(`FWSR_REG_STAT, s);
            chk("status", s[7:0] & ROWS[i].mask, {24'h0, ROWS[i].stat});
            rd(`FWSR_REG_RDAT, s);
            chk("array byte", s[7:0] & ROWS[i].rmask, {24'h0, ROWS[i].rdat});
        end
        // a one over a zero that keeps toggling long: abort, then reset the device
        busy_reads <= 8'hC8;
        start_op(OP_PROGRAM, 20'h00040, 8'hFF);
        repeat (300) @(posedge clk_sys);
        rd(`FWSR_REG_STAT, s);
        chk("busy with pin low", s[3:0] & 4'hD, 32'h1);
        wr(`FWSR_REG_CTRL, 32'h200);
        repeat (20) @(posedge clk_sys);
        chk("idle after abort", op_busy, 32'h0);
        start_op(OP_RESET, 20'h00040, 8'h00);
        wait_idle();
        rd(`FWSR_REG_STAT, s);
        chk("ready after reset", s[3:0], 32'hA);
        rd(`FWSR_REG_RDAT, s);
        chk("data kept", s, 32'h3C);
        rd(`FWSR_REG_ADDR, s);
        chk("poll address", s, 32'h40);
        // reset in mid-poll: pins idle and the status flags clear
        busy_reads <= 8'hC8;
        start_op(OP_PROGRAM, 20'h00040, 8'hFF);
        repeat (100) @(posedge clk_sys);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        chk("idle after reset", {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n,
            op_busy}, 32'h1E);
        rd(`FWSR_REG_STAT, s);
        chk("flags after reset", s[2:0], 32'h0);
        tally_and_finish();
    end
endmodule : flash_write_status_reporting_test
